// file: core/dipim_map.vh
// Purpose: Offsets, fields and reset values of the digital process image map
// Assumes: Register port with 8-bit word index addressing
// Notes:   Included by every design file
`ifndef DIPIM_MAP_VH
`define DIPIM_MAP_VH

`define DIPIM_AW               4
`define DIPIM_DW               8
// Register offsets
`define DIPIM_THERM_STATE      4'h0
`define DIPIM_THERM_FAULT      4'h1
`define DIPIM_THERM_RSVD_OUT   4'h2
`define DIPIM_THERM_DISABLE    4'h3
`define DIPIM_SIXTEEN_LOW      4'h4
`define DIPIM_SIXTEEN_HIGH     4'h5
`define DIPIM_MANUAL_STATUS    4'h6
`define DIPIM_SINGLE_CTRL      4'h7
`define DIPIM_DUAL_CTRL        4'h8
`define DIPIM_ANALOG_LEN       4'h9
`define DIPIM_IRQ_STATUS       4'hA
`define DIPIM_IRQ_MASK         4'hB
`define DIPIM_DIAG_BYTE        4'hC
// Field masks
`define DIPIM_SINGLE_MASK      8'h01
`define DIPIM_DUAL_MASK        8'h03
`define DIPIM_DIAG_MASK        8'h03
`define DIPIM_ZERO             8'h00
`define DIPIM_ONES             8'hFF
// Reset values
`define DIPIM_DISABLE_RST      8'h00
`define DIPIM_CTRL_RST         8'h00
`define DIPIM_ANALOG_RST       4'h0
// Interrupt status bits
`define DIPIM_IRQ_THERM_FAULT  0
`define DIPIM_IRQ_MANUAL       1
`define DIPIM_IRQ_DIAG         2
`define DIPIM_IRQ_W            3
// Output image packing
`define DIPIM_OUT_BYTES        16
`define DIPIM_DIG_BYTES        4

`endif

// file: core/dipim_edge_flags.v
// Purpose: Sticky event flags set by rising edges, write one to clear
// Assumes: Inputs synchronous to sys_clk_i
// Notes:   A set in the clear cycle wins
`timescale 1ns/1ps
`include "dipim_map.vh"

module dipim_edge_flags (
  input  wire                      sys_clk_i,
  input  wire                      rst_i,
  input  wire [`DIPIM_IRQ_W-1:0]   event_i,
  input  wire [`DIPIM_IRQ_W-1:0]   clear_i,
  output reg  [`DIPIM_IRQ_W-1:0]   flag_o
);

  reg [`DIPIM_IRQ_W-1:0] event_prev;

  genvar g;
  generate
    for (g = 0; g < `DIPIM_IRQ_W; g = g + 1) begin : g_flag
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          event_prev[g] <= 1'b0;
          flag_o[g]     <= 1'b0;
        end else begin
          event_prev[g] <= event_i[g];
          if (event_i[g] && !event_prev[g]) begin
            flag_o[g] <= 1'b1;
          end else if (clear_i[g]) begin
            flag_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

// file: core/dipim_out_packer.v
// Purpose: Places digital output bytes after the analog bytes of the output image
// Assumes: Analog length counts whole bytes
// Notes:   Bytes past the image end are dropped
`timescale 1ns/1ps
`include "dipim_map.vh"

module dipim_out_packer (
  input  wire                          sys_clk_i,
  input  wire                          rst_i,
  input  wire [`DIPIM_AW-1:0]          analog_len_i,
  input  wire [8*`DIPIM_DIG_BYTES-1:0] dig_bytes_i,
  input  wire [8*`DIPIM_OUT_BYTES-1:0] analog_image_i,
  output reg  [8*`DIPIM_OUT_BYTES-1:0] out_image_o
);

  genvar g;
  generate
    for (g = 0; g < `DIPIM_OUT_BYTES; g = g + 1) begin : g_byte
      localparam [4:0] BYTE_IDX = g;
      wire       [4:0] rel      = BYTE_IDX - {1'b0, analog_len_i};
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          out_image_o[8*g +: 8] <= `DIPIM_ZERO;
        end else if (BYTE_IDX < {1'b0, analog_len_i}) begin
          out_image_o[8*g +: 8] <= analog_image_i[8*g +: 8];
        end else if (rel < `DIPIM_DIG_BYTES) begin
          out_image_o[8*g +: 8] <= dig_bytes_i[8*rel +: 8];
        end else begin
          out_image_o[8*g +: 8] <= `DIPIM_ZERO;
        end
      end
    end
  endgenerate

endmodule

// file: core/dipim_top.v
// Purpose: Digital I/O process image map between module channels and controller
// Assumes: Channel inputs synchronous to sys_clk_i; 20 MHz clock
// Notes:   Register reads answer one cycle after the read strobe
//
// Overview of operation
// - Thermistor module uses two in, two out bytes
// - Input byte one holds channel states
// - Input byte two holds channel fault flags
// - Output byte two disables channels, one off
// - Sixteen inputs split low and high byte
// - One control bit drives each output
// - Diagnostic outputs add one fault bit each
// - Digital output bytes follow analog output data
// - Single output bit0 control, bit0 manual status
// - Dual output uses bits zero and one
`timescale 1ns/1ps
`include "dipim_map.vh"

module dipim_top (
  input  wire                          sys_clk_i,
  input  wire                          rst_i,
  input  wire [`DIPIM_AW-1:0]          addr_i,
  input  wire [`DIPIM_DW-1:0]          wdata_i,
  input  wire                          wr_i,
  input  wire                          rd_i,
  output reg  [`DIPIM_DW-1:0]          rdata_o,
  input  wire [7:0]                    therm_state_i,
  input  wire [7:0]                    therm_fault_i,
  output reg  [7:0]                    therm_enable_o,
  input  wire [15:0]                   sixteen_in_i,
  input  wire                          manual_op_i,
  output reg                           single_out_o,
  output reg  [1:0]                    dual_out_o,
  input  wire [1:0]                    dual_diag_i,
  input  wire [8*`DIPIM_OUT_BYTES-1:0] analog_image_i,
  output wire [8*`DIPIM_OUT_BYTES-1:0] out_image_o,
  output wire                          irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input image capture
  reg [7:0] therm_state;
  reg [7:0] therm_fault;
  reg [7:0] sixteen_low;
  reg [7:0] sixteen_high;
  reg [7:0] manual_status;
  reg [7:0] diag_byte;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      therm_state   <= `DIPIM_ZERO;
      therm_fault   <= `DIPIM_ZERO;
      sixteen_low   <= `DIPIM_ZERO;
      sixteen_high  <= `DIPIM_ZERO;
      manual_status <= `DIPIM_ZERO;
      diag_byte     <= `DIPIM_ZERO;
    end else begin
      therm_state   <= therm_state_i;
      therm_fault   <= therm_fault_i;
      sixteen_low   <= sixteen_in_i[7:0];
      sixteen_high  <= sixteen_in_i[15:8];
      manual_status <= {7'h00, manual_op_i};
      diag_byte     <= {6'h00, dual_diag_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output image registers
  reg [7:0]           therm_disable;
  reg [7:0]           single_ctrl;
  reg [7:0]           dual_ctrl;
  reg [`DIPIM_AW-1:0] analog_len;
  reg [`DIPIM_IRQ_W-1:0] irq_mask;

  wire wr_disable = wr_i && (addr_i == `DIPIM_THERM_DISABLE);
  wire wr_single  = wr_i && (addr_i == `DIPIM_SINGLE_CTRL);
  wire wr_dual    = wr_i && (addr_i == `DIPIM_DUAL_CTRL);
  wire wr_analog  = wr_i && (addr_i == `DIPIM_ANALOG_LEN);
  wire wr_mask    = wr_i && (addr_i == `DIPIM_IRQ_MASK);
  wire wr_status  = wr_i && (addr_i == `DIPIM_IRQ_STATUS);

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      therm_disable <= `DIPIM_DISABLE_RST;
      single_ctrl   <= `DIPIM_CTRL_RST;
      dual_ctrl     <= `DIPIM_CTRL_RST;
      analog_len    <= `DIPIM_ANALOG_RST;
      irq_mask      <= {`DIPIM_IRQ_W{1'b0}};
    end else begin
      if (wr_disable) begin
        therm_disable <= wdata_i;
      end
      if (wr_single) begin
        single_ctrl <= wdata_i & `DIPIM_SINGLE_MASK;
      end
      if (wr_dual) begin
        dual_ctrl <= wdata_i & `DIPIM_DUAL_MASK;
      end
      if (wr_analog) begin
        analog_len <= wdata_i[`DIPIM_AW-1:0];
      end
      if (wr_mask) begin
        irq_mask <= wdata_i[`DIPIM_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel drives
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      therm_enable_o <= `DIPIM_ONES;
      single_out_o   <= 1'b0;
      dual_out_o     <= 2'b00;
    end else begin
      therm_enable_o <= ~therm_disable;
      single_out_o   <= single_ctrl[0];
      dual_out_o     <= dual_ctrl[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output image packing
  // Thermistor module takes two output bytes: reserved zero byte, then disable byte
  wire [8*`DIPIM_DIG_BYTES-1:0] dig_bytes = {dual_ctrl, single_ctrl, therm_disable,
                                             `DIPIM_ZERO};

  dipim_out_packer u_packer (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .analog_len_i   (analog_len),
    .dig_bytes_i    (dig_bytes),
    .analog_image_i (analog_image_i),
    .out_image_o    (out_image_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  wire [`DIPIM_IRQ_W-1:0] irq_status;
  wire [`DIPIM_IRQ_W-1:0] irq_event;
  wire [`DIPIM_IRQ_W-1:0] irq_clear;

  assign irq_event[`DIPIM_IRQ_THERM_FAULT] = |therm_fault;
  assign irq_event[`DIPIM_IRQ_MANUAL]      = manual_status[0];
  assign irq_event[`DIPIM_IRQ_DIAG]        = |diag_byte;
  assign irq_clear = wr_status ? wdata_i[`DIPIM_IRQ_W-1:0] : {`DIPIM_IRQ_W{1'b0}};

  dipim_edge_flags u_flags (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .event_i   (irq_event),
    .clear_i   (irq_clear),
    .flag_o    (irq_status)
  );

  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  reg [7:0] next_rdata;

  always @* begin
    case (addr_i)
      `DIPIM_THERM_STATE:    next_rdata = therm_state;
      `DIPIM_THERM_FAULT:    next_rdata = therm_fault;
      `DIPIM_THERM_RSVD_OUT: next_rdata = `DIPIM_ZERO;
      `DIPIM_THERM_DISABLE:  next_rdata = therm_disable;
      `DIPIM_SIXTEEN_LOW:    next_rdata = sixteen_low;
      `DIPIM_SIXTEEN_HIGH:   next_rdata = sixteen_high;
      `DIPIM_MANUAL_STATUS:  next_rdata = manual_status;
      `DIPIM_SINGLE_CTRL:    next_rdata = single_ctrl;
      `DIPIM_DUAL_CTRL:      next_rdata = dual_ctrl;
      `DIPIM_ANALOG_LEN:     next_rdata = {4'h0, analog_len};
      `DIPIM_IRQ_STATUS:     next_rdata = {5'h00, irq_status};
      `DIPIM_IRQ_MASK:       next_rdata = {5'h00, irq_mask};
      `DIPIM_DIAG_BYTE:      next_rdata = diag_byte;
      default:               next_rdata = `DIPIM_ZERO;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= `DIPIM_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `DIPIM_ZERO;
    end
  end

endmodule

// file: tb/dipim_props.sv
// Purpose: Port checks of the process image map
// Assumes: One clock, sync reset
// Notes:   Bound to dipim_top
`timescale 1ns/1ps
`include "dipim_map.vh"

module dipim_props (
  input wire                 sys_clk_i,
  input wire                 rst_i,
  input wire [`DIPIM_AW-1:0] addr_i,
  input wire [`DIPIM_DW-1:0] wdata_i,
  input wire                 wr_i,
  input wire                 rd_i,
  input wire [`DIPIM_DW-1:0] rdata_o,
  input wire [7:0]           therm_state_i,
  input wire [7:0]           therm_fault_i,
  input wire [7:0]           therm_enable_o,
  input wire [15:0]          sixteen_in_i,
  input wire                 manual_op_i,
  input wire                 single_out_o,
  input wire [1:0]           dual_out_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_dis; wr_i && addr_i == 4'h3 |-> ##2 therm_enable_o == ~$past(wdata_i, 2); endproperty
  a_dis: assert property (p_dis) else $error("enable mismatch");
  property p_st; rd_i && addr_i == 4'h0 && $stable(therm_state_i) && !$past(rst_i)
    |-> ##1 rdata_o == $past(therm_state_i); endproperty
  a_st: assert property (p_st) else $error("state read");
  property p_flt; rd_i && addr_i == 4'h1 && $stable(therm_fault_i) && !$past(rst_i)
    |-> ##1 rdata_o == $past(therm_fault_i); endproperty
  a_flt: assert property (p_flt) else $error("fault read");
  property p_lo; rd_i && addr_i == 4'h4 && $stable(sixteen_in_i) && !$past(rst_i)
    |-> ##1 rdata_o == $past(sixteen_in_i[7:0]); endproperty
  a_lo: assert property (p_lo) else $error("low read");
  property p_hi; rd_i && addr_i == 4'h5 && $stable(sixteen_in_i) && !$past(rst_i)
    |-> ##1 rdata_o == $past(sixteen_in_i[15:8]); endproperty
  a_hi: assert property (p_hi) else $error("high read");
  property p_man; rd_i && addr_i == 4'h6 && $stable(manual_op_i) && !$past(rst_i)
    |-> ##1 rdata_o == {7'h0, $past(manual_op_i)}; endproperty
  a_man: assert property (p_man) else $error("manual read");
  property p_sgl; wr_i && addr_i == 4'h7 |-> ##2 single_out_o == $past(wdata_i[0], 2); endproperty
  a_sgl: assert property (p_sgl) else $error("single drive");
  property p_dul; wr_i && addr_i == 4'h8 |-> ##2 dual_out_o == $past(wdata_i[1:0], 2); endproperty
  a_dul: assert property (p_dul) else $error("dual drive");
  property p_rsv; rd_i && addr_i == 4'h2 |-> ##1 rdata_o == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read");
endmodule

bind dipim_top dipim_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .therm_state_i(therm_state_i), .therm_fault_i(therm_fault_i),
  .therm_enable_o(therm_enable_o), .sixteen_in_i(sixteen_in_i), .manual_op_i(manual_op_i),
  .single_out_o(single_out_o), .dual_out_o(dual_out_o));

// file: tb/dipim_field.sv
// Purpose: Module channels seen from the map
// Assumes: Levels change after a clock edge
// Notes:   Bench commands the levels
`timescale 1ns/1ps

module dipim_field (
  input  wire        sys_clk_i,
  input  wire [34:0] cmd_i,
  output reg  [34:0] pins_o
);
  initial pins_o = 35'h0;
  always @(posedge sys_clk_i) begin
    pins_o <= cmd_i;
  end
endmodule

// file: tb/tb_dipim_top.sv
// Purpose: Self-checking bench of the process image map
// Assumes: 20 MHz clock
// Notes:   Channel levels come from dipim_field
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end

module tb_dipim_top;
  reg          sys_clk_i, rst_i, wr_i, rd_i;
  reg  [3:0]   addr_i;
  reg  [7:0]   wdata_i;
  reg  [34:0]  cmd;
  reg  [127:0] analog_image_i;
  wire [34:0]  pins;
  wire [7:0]   rdata_o, therm_enable_o;
  wire [1:0]   dual_out_o;
  wire [127:0] out_image_o;
  wire         single_out_o, irq_o;
  int          miscompares = 0, n_tests = 0;

  dipim_field u_field (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .pins_o(pins));
  dipim_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .therm_state_i(pins[7:0]),
    .therm_fault_i(pins[15:8]), .therm_enable_o(therm_enable_o), .sixteen_in_i(pins[31:16]),
    .manual_op_i(pins[32]), .single_out_o(single_out_o), .dual_out_o(dual_out_o),
    .dual_diag_i(pins[34:33]), .analog_image_i(analog_image_i), .out_image_o(out_image_o),
    .irq_o(irq_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task wr(input [3:0] a, input [7:0] d);
    begin
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge sys_clk_i); wr_i <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] e);
    begin
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      // Read data stand only in the cycle after the strobe edge
      #1 `CHK(rdata_o, e)
      @(posedge sys_clk_i);
    end
  endtask
  task close_out;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_therm;
    begin
      cmd[15:0] <= 16'h3CA5;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(4'h0, 8'hA5);
      rd_chk(4'h1, 8'h3C);
      wr(4'h3, 8'h81);
      #1 `CHK(therm_enable_o, 8'h7E)
      @(posedge sys_clk_i);
      rd_chk(4'h3, 8'h81);
      wr(4'h2, 8'h00);
      rd_chk(4'h2, 8'h00);
      rd_chk(4'hD, 8'h00);
      cmd[31:16] <= 16'hBEEF;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(4'h4, 8'hEF);
      rd_chk(4'h5, 8'hBE);
      $display("Test thermistor and inputs done");
    end
  endtask
  task t_outs;
    begin
      wr(4'h7, 8'hFF);
      #1 `CHK(single_out_o, 1'b1)
      @(posedge sys_clk_i);
      wr(4'h8, 8'hFE);
      #1 `CHK(dual_out_o, 2'h2)
      @(posedge sys_clk_i);
      rd_chk(4'h7, 8'h01);
      rd_chk(4'h8, 8'h02);
      cmd[32] <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(4'h6, 8'h01);
      analog_image_i <= {8{16'h5A3C}};
      wr(4'h9, 8'h02);
      #1 `CHK(out_image_o, {80'h0, 48'h0201_8100_5A3C})
      @(posedge sys_clk_i);
      rd_chk(4'h9, 8'h02);
      $display("Test outputs and image done");
    end
  endtask
  task t_irq;
    begin
      cmd[34:33] <= 2'h2;
      repeat (4) @(posedge sys_clk_i);
      rd_chk(4'hC, 8'h02);
      rd_chk(4'h8, 8'h02);
      rd_chk(4'hA, 8'h07);
      #1 `CHK(irq_o, 1'b0)
      @(posedge sys_clk_i);
      wr(4'hB, 8'h04);
      #1 `CHK(irq_o, 1'b1)
      @(posedge sys_clk_i);
      rd_chk(4'hB, 8'h04);
      wr(4'hA, 8'h07);
      #1 `CHK(irq_o, 1'b0)
      @(posedge sys_clk_i);
      rd_chk(4'hA, 8'h00);
      $display("Test interrupts done");
    end
  endtask
  task t_reset;
    begin
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1 `CHK(therm_enable_o, 8'hFF)
      `CHK(single_out_o, 1'b0)
      `CHK(dual_out_o, 2'h0)
      `CHK(out_image_o, 128'h0)
      `CHK(irq_o, 1'b0)
      `CHK(rdata_o, 8'h00)
      @(posedge sys_clk_i);
      $display("Test mid-run reset done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    miscompares++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out;
  end
  initial begin
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00;
    cmd = 35'h0; analog_image_i = 128'h0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 `CHK(therm_enable_o, 8'hFF)
    @(posedge sys_clk_i);
    t_therm;
    t_outs;
    t_irq;
    t_reset;
    close_out;
  end
endmodule
